// File: rtl/rpm_irq_ctrl.sv
// Sticky event status, mask, level interrupt and latched interrupt pin
`timescale 1ns/1ns
`default_nettype none
module rpm_irq_ctrl
    import rpm_pkg::*;
(
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_b_i,
    input  wire logic                   supply_clr_i,
    input  wire logic [`RPM_NUM_EV-1:0] ev_lvl_i,
    input  wire logic                   status_wr_i,
    input  wire logic                   mask_wr_i,
    input  wire logic                   clr_cmd_i,
    input  wire logic [`RPM_NUM_EV-1:0] wdata_i,
    output logic      [`RPM_NUM_EV-1:0] status_o,
    output logic      [`RPM_NUM_EV-1:0] mask_o,
    output logic                        irq_o,
    output logic                        pin_low_o
);
    import rpm_pkg::*;

    rpm_irq_st_type st_q;
    rpm_irq_st_type st_d;

    always_comb begin
        logic [`RPM_NUM_EV-1:0] rise;
        logic [`RPM_NUM_EV-1:0] w1c;
        rise = '0;
        w1c  = '0;
        st_d = st_q;
        // Only a new condition raises an event, so a lasting fault does not
        // re-assert the pin the moment it has been cleared
        rise = ev_lvl_i & ~st_q.ev_prev;
        w1c  = status_wr_i ? wdata_i : '0;
        st_d.ev_prev = ev_lvl_i;
        st_d.status  = (st_q.status & ~w1c) | rise;
        if (mask_wr_i) begin
            st_d.mask = wdata_i;
        end
        st_d.pin_low = (st_q.pin_low & ~clr_cmd_i) | (|rise);
        if (supply_clr_i) begin
            st_d.status  = `RPM_IRQ_STATUS_RST;
            st_d.mask    = `RPM_IRQ_MASK_RST;
            st_d.pin_low = 1'b0;
        end
        st_d.irq = |(st_d.status & st_d.mask);
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign status_o  = st_q.status;
    assign mask_o    = st_q.mask;
    assign irq_o     = st_q.irq;
    assign pin_low_o = st_q.pin_low;
endmodule
`default_nettype wire

// File: rtl/rpm_params.svh
// Register offsets, field positions, reset values and widths of the regulator control block
`ifndef RPM_PARAMS_SVH
`define RPM_PARAMS_SVH

`define RPM_ADDR_W          5
`define RPM_DATA_W          32

`define RPM_OFF_LDO_CTRL    5'h00
`define RPM_OFF_SW_CTRL     5'h04
`define RPM_OFF_STATUS      5'h08
`define RPM_OFF_IRQ_STATUS  5'h0C
`define RPM_OFF_IRQ_MASK    5'h10
`define RPM_OFF_IRQ_CLEAR   5'h14

`define RPM_NUM_LDO         3
`define RPM_NUM_SW          4
`define RPM_NUM_REG         7
`define RPM_NUM_EV          5

`define RPM_SW_SLEW_MASK_BIT 4

`define RPM_ST_EN_LSB       0
`define RPM_ST_PG_LSB       7
`define RPM_ST_SLEW_BIT     14
`define RPM_ST_IRQPIN_BIT   15
`define RPM_ST_PGPIN_BIT    16
`define RPM_ST_MASTER_BIT   17

`define RPM_EV_PG_BAD       0
`define RPM_EV_UV_WARN      1
`define RPM_EV_UV_FAULT     2
`define RPM_EV_OT_WARN      3
`define RPM_EV_OT_FAULT     4

`define RPM_LDO_CMD_RST     3'h0
`define RPM_SW_CMD_RST      4'h0
`define RPM_SLEW_MASK_RST   1'h0
`define RPM_IRQ_MASK_RST    5'h00
`define RPM_IRQ_STATUS_RST  5'h00

`define RPM_SYNC_W          26

`endif

// File: rtl/rpm_pkg.sv
// Types of the regulator control block
package rpm_pkg;

`include "rpm_params.svh"

    typedef struct packed {
        logic [`RPM_SYNC_W-1:0] s1;
        logic [`RPM_SYNC_W-1:0] s2;
    } rpm_sync_st_type;

    typedef struct packed {
        logic [`RPM_NUM_EV-1:0] status;
        logic [`RPM_NUM_EV-1:0] mask;
        logic [`RPM_NUM_EV-1:0] ev_prev;
        logic                   pin_low;
        logic                   irq;
    } rpm_irq_st_type;

    typedef struct packed {
        logic [`RPM_NUM_LDO-1:0] ldo_cmd;
        logic [`RPM_NUM_SW-1:0]  sw_cmd;
        logic                    slew_mask;
        logic [`RPM_NUM_LDO-1:0] ldo_en;
        logic [`RPM_NUM_SW-1:0]  sw_en;
        logic                    pg_low;
        logic                    waitreq;
        logic [`RPM_DATA_W-1:0]  readdata;
    } rpm_top_st_type;

endpackage

// File: rtl/rpm_sync.sv
// Two-stage synchroniser for all asynchronous inputs of the block
`timescale 1ns/1ns
`default_nettype none
module rpm_sync
    import rpm_pkg::*;
(
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_b_i,
    input  wire logic [`RPM_SYNC_W-1:0] async_i,
    output logic      [`RPM_SYNC_W-1:0] sync_o
);
    import rpm_pkg::*;

    rpm_sync_st_type st_q;
    rpm_sync_st_type st_d;

    // First stage feeds only the second stage
    always_comb begin
        st_d    = st_q;
        st_d.s1 = async_i;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_o = st_q.s2;
endmodule
`default_nettype wire

// File: rtl/rpm_top.sv
// Regulator enable, power-good and interrupt control with Avalon-MM registers
// Contract
// - Each linear-regulator enable pin is active high and reads low when left open.
// - Each switching-regulator enable pin is active high and reads low when left open.
// - While master power-on is low all enables are ignored; while high they act normally.
// - When the serial-port supply falls below its threshold every register returns to reset.
// - The open-drain interrupt pin is pulled low on any power-good, undervoltage or
//       overtemperature warning or fault.
// - A write to the interrupt-clear command register releases the interrupt pin.
// - Power-good is pulled low whenever an enabled regulator is below its threshold.
// - Power-good is pulled low during an output-voltage slew unless a command bit masks it.
// - Power-good is pulled low whenever every regulator is disabled.
// - Each linear regulator has a command enable bit, reset 0, which otherwise defers
//        to the pin.
// - Each switching regulator has a command enable bit, reset 0, 1 forcing it on.
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module rpm_top
    import rpm_pkg::*;
(
    input  wire logic                    core_clk_i,
    input  wire logic                    rst_b_i,
    // Avalon-MM slave
    input  wire logic [`RPM_ADDR_W-1:0]  avs_address_i,
    input  wire logic                    avs_read_i,
    input  wire logic                    avs_write_i,
    input  wire logic [`RPM_DATA_W-1:0]  avs_writedata_i,
    input  wire logic [3:0]              avs_byteenable_i,
    output logic      [`RPM_DATA_W-1:0]  avs_readdata_o,
    output logic                         avs_waitrequest_o,
    // Regulator enable pins and master power-on
    input  wire logic [`RPM_NUM_LDO-1:0] ldo_enable_in_i,
    input  wire logic [`RPM_NUM_SW-1:0]  sw_reg_enable_in_i,
    input  wire logic                    master_power_on_i,
    // Serial-port supply comparator, high while above threshold
    input  wire logic                    serial_logic_supply_ok_i,
    // Analog monitors
    input  wire logic [`RPM_NUM_REG-1:0] reg_above_pg_i,
    input  wire logic [`RPM_NUM_SW-1:0]  sw_slew_active_i,
    input  wire logic                    uv_warn_i,
    input  wire logic                    uv_fault_i,
    input  wire logic                    ot_warn_i,
    input  wire logic                    ot_fault_i,
    // Regulator enables to the analog side
    output logic      [`RPM_NUM_LDO-1:0] ldo_en_o,
    output logic      [`RPM_NUM_SW-1:0]  sw_en_o,
    // Open-drain interrupt pin
    input  wire logic                    irq_pin_i,
    output logic                         irq_pin_o,
    output logic                         irq_pin_oe_o,
    // Open-drain power-good pin
    input  wire logic                    power_good_out_i,
    output logic                         power_good_out_o,
    output logic                         power_good_out_oe_o,
    // Level interrupt to the local processor
    output logic                         irq_o
);
    import rpm_pkg::*;

    rpm_top_st_type st_q;
    rpm_top_st_type st_d;

    logic [`RPM_SYNC_W-1:0] async_in;
    logic [`RPM_SYNC_W-1:0] sync_in;

    logic [`RPM_NUM_LDO-1:0] ldo_pin_s;
    logic [`RPM_NUM_SW-1:0]  sw_pin_s;
    logic                    master_s;
    logic                    supply_ok_s;
    logic [`RPM_NUM_REG-1:0] pg_s;
    logic [`RPM_NUM_SW-1:0]  slew_s;
    logic                    uv_warn_s;
    logic                    uv_fault_s;
    logic                    ot_warn_s;
    logic                    ot_fault_s;
    logic                    irq_pin_s;
    logic                    pg_pin_s;

    logic [`RPM_NUM_EV-1:0]  ev_lvl;
    logic [`RPM_NUM_EV-1:0]  irq_status;
    logic [`RPM_NUM_EV-1:0]  irq_mask;
    logic                    irq_lvl;
    logic                    irq_pin_low;

    logic                    acc_wr;
    logic                    lane0;
    logic                    wr_status;
    logic                    wr_mask;
    logic                    wr_clear;

    // Pad pull-downs make an open enable pin arrive here as a low level
    assign async_in = {power_good_out_i, irq_pin_i, ot_fault_i, ot_warn_i, uv_fault_i,
                       uv_warn_i, sw_slew_active_i, reg_above_pg_i, serial_logic_supply_ok_i,
                       master_power_on_i, sw_reg_enable_in_i, ldo_enable_in_i};

    rpm_sync u_sync (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .async_i    (async_in),
        .sync_o     (sync_in)
    );

    assign ldo_pin_s   = sync_in[2:0];
    assign sw_pin_s    = sync_in[6:3];
    assign master_s    = sync_in[7];
    assign supply_ok_s = sync_in[8];
    assign pg_s        = sync_in[15:9];
    assign slew_s      = sync_in[19:16];
    assign uv_warn_s   = sync_in[20];
    assign uv_fault_s  = sync_in[21];
    assign ot_warn_s   = sync_in[22];
    assign ot_fault_s  = sync_in[23];
    assign irq_pin_s   = sync_in[24];
    assign pg_pin_s    = sync_in[25];

    // Address match of a request that is being accepted on this edge
    function automatic logic hit(input logic [`RPM_ADDR_W-1:0] a,
                                 input logic [`RPM_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // Accept edge: request seen while waitrequest is already low
    assign acc_wr    = avs_write_i && !st_q.waitreq;
    assign lane0     = avs_byteenable_i[0];
    assign wr_status = acc_wr && lane0 && hit(avs_address_i, `RPM_OFF_IRQ_STATUS);
    assign wr_mask   = acc_wr && lane0 && hit(avs_address_i, `RPM_OFF_IRQ_MASK);
    // Any write to the clear command releases the pin, whatever the data
    assign wr_clear  = acc_wr && hit(avs_address_i, `RPM_OFF_IRQ_CLEAR);

    assign ev_lvl[`RPM_EV_PG_BAD]   = st_q.pg_low && (|(st_q.ldo_en)) | (|(st_q.sw_en));
    assign ev_lvl[`RPM_EV_UV_WARN]  = uv_warn_s;
    assign ev_lvl[`RPM_EV_UV_FAULT] = uv_fault_s;
    assign ev_lvl[`RPM_EV_OT_WARN]  = ot_warn_s;
    assign ev_lvl[`RPM_EV_OT_FAULT] = ot_fault_s;

    rpm_irq_ctrl u_irq (
        .core_clk_i   (core_clk_i),
        .rst_b_i      (rst_b_i),
        .supply_clr_i (!supply_ok_s),
        .ev_lvl_i     (ev_lvl),
        .status_wr_i  (wr_status),
        .mask_wr_i    (wr_mask),
        .clr_cmd_i    (wr_clear),
        .wdata_i      (avs_writedata_i[`RPM_NUM_EV-1:0]),
        .status_o     (irq_status),
        .mask_o       (irq_mask),
        .irq_o        (irq_lvl),
        .pin_low_o    (irq_pin_low)
    );

    always_comb begin
        logic [`RPM_NUM_REG-1:0] en_all;
        logic [`RPM_DATA_W-1:0]  rd;
        en_all = '0;
        rd     = '0;
        st_d   = st_q;

        // Bus: one wait cycle, then accept; readdata captured on the wait edge
        case (avs_address_i)
            `RPM_OFF_LDO_CTRL: begin
                rd[`RPM_NUM_LDO-1:0] = st_q.ldo_cmd;
            end
            `RPM_OFF_SW_CTRL: begin
                rd[`RPM_NUM_SW-1:0]          = st_q.sw_cmd;
                rd[`RPM_SW_SLEW_MASK_BIT]    = st_q.slew_mask;
            end
            `RPM_OFF_STATUS: begin
                rd[`RPM_ST_EN_LSB +: `RPM_NUM_REG] = {st_q.sw_en, st_q.ldo_en};
                rd[`RPM_ST_PG_LSB +: `RPM_NUM_REG] = pg_s;
                rd[`RPM_ST_SLEW_BIT]   = |slew_s;
                rd[`RPM_ST_IRQPIN_BIT] = irq_pin_s;
                rd[`RPM_ST_PGPIN_BIT]  = pg_pin_s;
                rd[`RPM_ST_MASTER_BIT] = master_s;
            end
            `RPM_OFF_IRQ_STATUS: begin
                rd[`RPM_NUM_EV-1:0] = irq_status;
            end
            `RPM_OFF_IRQ_MASK: begin
                rd[`RPM_NUM_EV-1:0] = irq_mask;
            end
            default: begin
                rd = '0;
            end
        endcase

        if ((avs_read_i || avs_write_i) && st_q.waitreq) begin
            st_d.waitreq = 1'b0;
            if (avs_read_i) begin
                st_d.readdata = rd;
            end
        end else begin
            st_d.waitreq = 1'b1;
        end

        if (acc_wr && lane0) begin
            case (avs_address_i)
                `RPM_OFF_LDO_CTRL: begin
                    st_d.ldo_cmd = avs_writedata_i[`RPM_NUM_LDO-1:0];
                end
                `RPM_OFF_SW_CTRL: begin
                    st_d.sw_cmd    = avs_writedata_i[`RPM_NUM_SW-1:0];
                    st_d.slew_mask = avs_writedata_i[`RPM_SW_SLEW_MASK_BIT];
                end
                default: begin
                    st_d.ldo_cmd = st_q.ldo_cmd;
                end
            endcase
        end

        // Master power-on gates pins and command bits alike
        st_d.ldo_en = master_s ? (ldo_pin_s | st_q.ldo_cmd) : '0;
        st_d.sw_en  = master_s ? (sw_pin_s | st_q.sw_cmd) : '0;

        en_all      = {st_q.sw_en, st_q.ldo_en};
        st_d.pg_low = (|(en_all & ~pg_s))
                    || ((|(st_q.sw_en & slew_s)) && !st_q.slew_mask)
                    || (en_all == '0);

        // Loss of the serial-port supply drops the register file to defaults
        if (!supply_ok_s) begin
            st_d.ldo_cmd   = `RPM_LDO_CMD_RST;
            st_d.sw_cmd    = `RPM_SW_CMD_RST;
            st_d.slew_mask = `RPM_SLEW_MASK_RST;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q          <= '0;
            st_q.waitreq  <= 1'b1;
            st_q.pg_low   <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign avs_readdata_o      = st_q.readdata;
    assign avs_waitrequest_o   = st_q.waitreq;
    assign ldo_en_o            = st_q.ldo_en;
    assign sw_en_o             = st_q.sw_en;
    // Open-drain pins only ever drive low; the enable carries the level
    assign irq_pin_o           = 1'b0;
    assign irq_pin_oe_o        = irq_pin_low;
    assign power_good_out_o    = 1'b0;
    assign power_good_out_oe_o = st_q.pg_low;
    assign irq_o               = irq_lvl;
endmodule
`default_nettype wire

// File: verif/regulator_enable_status_logic_tb_top.sv
// Self-checking bench of the regulator control block
`timescale 1ns/1ns
`default_nettype none
`include "rpm_params.svh"
module regulator_enable_status_logic_tb_top;
    import rpm_pkg::*;
    typedef struct packed {
        logic m; logic [2:0] lp; logic [3:0] sp; logic [2:0] lc; logic [3:0] sc;
        logic [2:0] el; logic [3:0] es;
    } rpm_row_type;
    rpm_row_type rows [6] = '{
        '{1'b0, 3'h7, 4'hF, 3'h0, 4'h0, 3'h0, 4'h0}, '{1'b0, 3'h0, 4'h0, 3'h7, 4'hF, 3'h0, 4'h0},
        '{1'b1, 3'h5, 4'h6, 3'h0, 4'h0, 3'h5, 4'h6}, '{1'b1, 3'h0, 4'h0, 3'h2, 4'h9, 3'h2, 4'h9},
        '{1'b1, 3'h0, 4'h0, 3'h0, 4'h0, 3'h0, 4'h0}, '{1'b1, 3'h7, 4'hF, 3'h0, 4'h0, 3'h7, 4'hF}};
    logic core_clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0, master = 1'b0;
    logic supply_ok = 1'b1, waitreq, irq_d, irq_oe, pg_d, pg_oe, irq_line, pg_line, irq;
    logic [4:0]  address = 5'h00;
    logic [31:0] writedata = 32'h0, readdata;
    logic [3:0]  byteenable = 4'hF, sw_pin = 4'h0, slew = 4'h0, ev = 4'h0, sw_en;
    logic [2:0]  ldo_pin = 3'h0, ldo_en;
    logic [6:0]  above = 7'h7F;
    int errors = 0, total_checks = 0;
    always #50 core_clk = ~core_clk;
    rpm_top u_dut (.core_clk_i(core_clk), .rst_b_i(rst_b), .avs_address_i(address),
        .avs_read_i(read), .avs_write_i(write), .avs_writedata_i(writedata),
        .avs_byteenable_i(byteenable), .avs_readdata_o(readdata), .avs_waitrequest_o(waitreq),
        .ldo_enable_in_i(ldo_pin), .sw_reg_enable_in_i(sw_pin), .master_power_on_i(master),
        .serial_logic_supply_ok_i(supply_ok), .reg_above_pg_i(above), .sw_slew_active_i(slew),
        .uv_warn_i(ev[0]), .uv_fault_i(ev[1]), .ot_warn_i(ev[2]), .ot_fault_i(ev[3]),
        .ldo_en_o(ldo_en), .sw_en_o(sw_en), .irq_pin_i(irq_line), .irq_pin_o(irq_d),
        .irq_pin_oe_o(irq_oe), .power_good_out_i(pg_line), .power_good_out_o(pg_d),
        .power_good_out_oe_o(pg_oe), .irq_o(irq));
    rpm_board_model u_board (.irq_drive_i(irq_d), .irq_oe_i(irq_oe), .pg_drive_i(pg_d),
        .pg_oe_i(pg_oe), .irq_line_o(irq_line), .pg_line_o(pg_line));
    task automatic close_out();
        $display("checks %0d, errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    // Request held until waitrequest is sampled low, then released on that edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge core_clk);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= wd;
        // No own limit: a slave that never answers is caught by the watchdog
        do begin
            @(posedge core_clk);
        end while (waitreq !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] t;
        bus(1'b1, a, d, t);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] t;
        bus(1'b0, a, 32'h0, t);
        check(t, exp);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    initial begin
        #1_000_000;
        errors++;
        $display("unexpected at %0t: timeout", $time);
        close_out();
    end
    initial begin
        wait_cyc(4);
        check(32'(waitreq), 32'h1);
        check(32'(pg_oe), 32'h1);
        check(32'(irq_oe), 32'h0);
        @(posedge core_clk);
        rst_b <= 1'b1;
        rdc(`RPM_OFF_LDO_CTRL, 32'h0);
        rdc(`RPM_OFF_SW_CTRL, 32'h0);
        rdc(`RPM_OFF_IRQ_STATUS, 32'h0);
        rdc(`RPM_OFF_IRQ_MASK, 32'h0);
        rdc(`RPM_OFF_IRQ_CLEAR, 32'h0);
        // All rails off: rail monitors high, interrupt net released, power-good net low
        rdc(`RPM_OFF_STATUS, 32'h0000BF80);
        wr(5'h18, 32'hFFFFFFFF);
        rdc(5'h18, 32'h0);
        byteenable <= 4'h0;
        wr(`RPM_OFF_LDO_CTRL, 32'h7);
        byteenable <= 4'hF;
        rdc(`RPM_OFF_LDO_CTRL, 32'h0);
        for (int i = 0; i < 6; i++) begin
            wr(`RPM_OFF_LDO_CTRL, 32'(rows[i].lc));
            wr(`RPM_OFF_SW_CTRL, 32'(rows[i].sc));
            master <= rows[i].m;
            ldo_pin <= rows[i].lp;
            sw_pin <= rows[i].sp;
            wait_cyc(5);
            check(32'(ldo_en), 32'(rows[i].el));
            check(32'(sw_en), 32'(rows[i].es));
            check(32'(pg_oe), 32'(rows[i].el == 3'h0 && rows[i].es == 4'h0));
        end
        wr(`RPM_OFF_LDO_CTRL, 32'h0);
        ldo_pin <= 3'h1;
        sw_pin <= 4'h0;
        wait_cyc(6);
        check(32'(pg_oe), 32'h0);
        above <= 7'h7E;
        wait_cyc(6);
        check(32'(pg_oe), 32'h1);
        check(32'(irq_line), 32'h0);
        above <= 7'h7F;
        sw_pin <= 4'h1;
        slew <= 4'h1;
        wait_cyc(6);
        check(32'(pg_oe), 32'h1);
        rdc(`RPM_OFF_STATUS, 32'h00027F89);
        wr(`RPM_OFF_SW_CTRL, 32'h10);
        wait_cyc(6);
        check(32'(pg_oe), 32'h0);
        slew <= 4'h0;
        wr(`RPM_OFF_IRQ_STATUS, 32'h1F);
        wr(`RPM_OFF_IRQ_CLEAR, 32'h0);
        wait_cyc(3);
        check(32'(irq_oe), 32'h0);
        rdc(`RPM_OFF_IRQ_STATUS, 32'h0);
        for (int i = 0; i < 4; i++) begin
            ev[i] <= 1'b1;
            wait_cyc(6);
            check(32'(irq_oe), 32'h1);
            check(32'(irq), 32'h0);
            rdc(`RPM_OFF_IRQ_STATUS, 32'h2 << i);
            ev[i] <= 1'b0;
            wait_cyc(6);
            check(32'(irq_oe), 32'h1);
            wr(`RPM_OFF_IRQ_CLEAR, 32'h0);
            wait_cyc(3);
            check(32'(irq_oe), 32'h0);
            wr(`RPM_OFF_IRQ_STATUS, 32'h2 << i);
            rdc(`RPM_OFF_IRQ_STATUS, 32'h0);
        end
        wr(`RPM_OFF_IRQ_MASK, 32'h10);
        ev[3] <= 1'b1;
        wait_cyc(6);
        check(32'(irq), 32'h1);
        ev[3] <= 1'b0;
        wr(`RPM_OFF_IRQ_STATUS, 32'h10);
        wait_cyc(3);
        check(32'(irq), 32'h0);
        wr(`RPM_OFF_IRQ_CLEAR, 32'h0);
        wr(`RPM_OFF_LDO_CTRL, 32'h7);
        supply_ok <= 1'b0;
        wait_cyc(5);
        supply_ok <= 1'b1;
        wait_cyc(4);
        rdc(`RPM_OFF_LDO_CTRL, 32'h0);
        rdc(`RPM_OFF_IRQ_MASK, 32'h0);
        // Reset in mid-run, with rails on and a command bit just written
        wr(`RPM_OFF_LDO_CTRL, 32'h7);
        rst_b <= 1'b0;
        wait_cyc(2);
        check(32'({ldo_en, sw_en, pg_oe, irq_oe, waitreq}), 32'h5);
        rst_b <= 1'b1;
        rdc(`RPM_OFF_LDO_CTRL, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire

// File: verif/rpm_board_model.sv
// Board side of the two open-drain pins: pull-ups resolving each net
`timescale 1ns/1ns
`default_nettype none
module rpm_board_model (
    input  wire logic irq_drive_i,
    input  wire logic irq_oe_i,
    input  wire logic pg_drive_i,
    input  wire logic pg_oe_i,
    output logic      irq_line_o,
    output logic      pg_line_o
);
    // Released nets rise through the pull-up, never hold the last driven level
    assign irq_line_o = irq_oe_i ? irq_drive_i : 1'b1;
    assign pg_line_o  = pg_oe_i ? pg_drive_i : 1'b1;
endmodule
`default_nettype wire

// File: verif/rpm_chk.sv
// Port-level assertions on the regulator control block
`timescale 1ns/1ns
`default_nettype none
`include "rpm_params.svh"
module rpm_chk
    import rpm_pkg::*;
(
    input wire logic                    core_clk_i,
    input wire logic                    rst_b_i,
    input wire logic [`RPM_ADDR_W-1:0]  avs_address_i,
    input wire logic                    avs_read_i,
    input wire logic                    avs_write_i,
    input wire logic                    avs_waitrequest_o,
    input wire logic [`RPM_NUM_LDO-1:0] ldo_enable_in_i,
    input wire logic [`RPM_NUM_SW-1:0]  sw_reg_enable_in_i,
    input wire logic                    master_power_on_i,
    input wire logic                    serial_logic_supply_ok_i,
    input wire logic [`RPM_NUM_REG-1:0] reg_above_pg_i,
    input wire logic                    uv_warn_i,
    input wire logic                    uv_fault_i,
    input wire logic                    ot_warn_i,
    input wire logic                    ot_fault_i,
    input wire logic [`RPM_NUM_LDO-1:0] ldo_en_o,
    input wire logic [`RPM_NUM_SW-1:0]  sw_en_o,
    input wire logic                    irq_pin_o,
    input wire logic                    irq_pin_oe_o,
    input wire logic                    power_good_out_i,
    input wire logic                    power_good_out_o,
    input wire logic                    power_good_out_oe_o
);
    logic [1:0] age_q;
    logic       clr_acc;
    logic       ev_any;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Sync and enable stages still hold reset values for three edges
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end
    assign clr_acc = avs_write_i && !avs_waitrequest_o && avs_address_i == `RPM_OFF_IRQ_CLEAR;
    assign ev_any  = uv_warn_i | uv_fault_i | ot_warn_i | ot_fault_i;
    sequence s_req_wait;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_quiet;
        !ev_any && $stable(power_good_out_i) && $stable(power_good_out_oe_o);
    endsequence
    property p_master_off;
        age_q == 2'h3 && $past(master_power_on_i, 3) == 1'b0 |-> ldo_en_o == 0 && sw_en_o == 0;
    endproperty
    property p_ldo_pin;
        age_q == 2'h3 && $past(master_power_on_i, 3)
            |-> (ldo_en_o & $past(ldo_enable_in_i, 3)) == $past(ldo_enable_in_i, 3);
    endproperty
    property p_sw_pin;
        age_q == 2'h3 && $past(master_power_on_i, 3)
            |-> (sw_en_o & $past(sw_reg_enable_in_i, 3)) == $past(sw_reg_enable_in_i, 3);
    endproperty
    property p_all_off;
        ldo_en_o == 0 && sw_en_o == 0 |=> power_good_out_oe_o;
    endproperty
    property p_pg_below;
        (age_q == 2'h3 && (|({sw_en_o, ldo_en_o} & ~reg_above_pg_i))
            && $stable(reg_above_pg_i))[*3] |=> power_good_out_oe_o;
    endproperty
    property p_irq_set;
        $rose(ev_any) |-> ##[1:4] irq_pin_oe_o;
    endproperty
    property p_irq_hold;
        irq_pin_oe_o && !clr_acc && serial_logic_supply_ok_i
            && $past(serial_logic_supply_ok_i) && $past(serial_logic_supply_ok_i, 2)
            |=> irq_pin_oe_o;
    endproperty
    property p_irq_clear;
        s_quiet [*3] ##0 clr_acc |=> !irq_pin_oe_o;
    endproperty
    property p_wait_one;
        s_req_wait |=> !avs_waitrequest_o;
    endproperty
    property p_wait_pulse;
        !avs_waitrequest_o |=> avs_waitrequest_o;
    endproperty
    property p_open_drain;
        irq_pin_o == 1'b0 && power_good_out_o == 1'b0;
    endproperty
    a_master_off: assert property (p_master_off) else $error("enable with master off");
    a_ldo_pin: assert property (p_ldo_pin) else $error("ldo pin ignored");
    a_sw_pin: assert property (p_sw_pin) else $error("switcher pin ignored");
    a_all_off: assert property (p_all_off) else $error("power good high, all off");
    a_pg_below: assert property (p_pg_below) else $error("power good high, rail low");
    a_irq_set: assert property (p_irq_set) else $error("interrupt pin not pulled");
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt pin let go");
    a_irq_clear: assert property (p_irq_clear) else $error("interrupt pin not released");
    a_wait_one: assert property (p_wait_one) else $error("wait state count wrong");
    a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
    a_open_drain: assert property (p_open_drain) else $error("open drain drives high");
endmodule
bind rpm_top rpm_chk u_chk (.core_clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_waitrequest_o, .ldo_enable_in_i, .sw_reg_enable_in_i, .master_power_on_i,
    .serial_logic_supply_ok_i, .reg_above_pg_i, .uv_warn_i, .uv_fault_i, .ot_warn_i,
    .ot_fault_i, .ldo_en_o, .sw_en_o, .irq_pin_o, .irq_pin_oe_o, .power_good_out_i,
    .power_good_out_o, .power_good_out_oe_o);
`default_nettype wire
